// ### hdl/asc_sequencer.sv
// Purpose: Sequencing and status logic of an 8-channel converter
// Assumes: Converter core on the same clock; trigger pin asynchronous
// Notes:   APB slave, zero wait states, read data registered in setup
//
// How it works
// - Conversion clock is bus clock over 2(p+1)
// - Start-control write aborts and restarts sequence, or arms it when trigger enabled
// - Scan bit repeats sequences, else one only
// - Single mode converts the selected channel only
// - Multi mode steps channel code per conversion
// - Stepped channel code wraps seven to zero
// - Channel code maps straight to input number
// - Length code zero or top bit means eight
// - Done flag set at every sequence end
// - Done flag cleared by write, restart, fast read
// - Result read clears its conversion flag after a flag read or in fast mode
// - Extra trigger edge while busy sets overrun in edge mode
// - Trigger overrun cleared by write or control writes
// - Overwriting unread result sets result overrun
// - Result overrun cleared by write or sequence start, not scan repeat
// - Three-bit result pointer shown in status
// - Pointer resets per sequence unless FIFO mode
// - Pointer wraps; status writes never touch it
// - Test register reads zero, ignores writes
// - Interrupt follows done flag when enabled
`timescale 1ns/1ps
module asc_sequencer
    import asc_pkg::*;
#(
    parameter int CHANNELS = 8,
    parameter int RES_W    = 10
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    // Converter core
    output logic                  conv_tick,
    output logic                  core_start,
    output logic                  core_abort,
    output logic [2:0]            core_channel,
    input  wire logic             core_done,
    input  wire logic [RES_W-1:0] core_result,
    // External trigger pin and interrupt request
    input  wire logic             trig_pin,
    output logic                  seq_irq
);
    // Length code to conversion count, 1..8
    function automatic logic [3:0] seq_len(input logic [3:0] code);
        if (code[3] || code == 4'h0) begin
            seq_len = 4'h8;
        end else begin
            seq_len = {1'b0, code[2:0]};
        end
    endfunction : seq_len

    logic [7:0]       tic;
    logic [7:0]       lfc;
    logic [4:0]       clock_prescale_value;
    logic [7:0]       ssc;
    logic             done_flag;
    logic             tovr_flag;
    logic             rovr_flag;
    logic [2:0]       ptr;
    logic [2:0]       chan;
    logic [3:0]       conv_cnt;
    logic [7:0]       ccf;
    logic [7:0]       ccf_armed;
    logic [RES_W-1:0] result [CHANNELS];
    logic [4:0]       div_cnt;
    logic             div_phase;
    logic             trig_s1;
    logic             trig_s2;
    logic             trig_s3;
    logic             trig_lvl;
    logic             trig_prev;
    asc_state_type    state;
    asc_state_type    next_state;

    // Bus decode
    wire       acc       = psel & penable;
    wire       wr        = acc & pwrite;
    wire       rd        = acc & ~pwrite;
    wire       setup     = psel & ~penable;
    wire       is_res    = paddr >= OFS_RES0 && paddr <= OFS_RES7 && paddr[1:0] == 2'b00;
    wire [2:0] res_idx   = paddr[4:2];
    wire       mapped    = (paddr[1:0] == 2'b00) && (paddr <= OFS_CCF || is_res);
    wire       wr_tic    = wr && paddr == OFS_TRIG;
    wire       wr_lfc    = wr && paddr == OFS_LEN;
    wire       wr_clk    = wr && paddr == OFS_CLK;
    wire       wr_ssc    = wr && paddr == OFS_START;
    wire       wr_stat   = wr && paddr == OFS_STAT;
    wire       rd_ccf    = rd && paddr == OFS_CCF;
    wire       rd_res    = rd && is_res;
    wire       abort_wr  = wr_tic | wr_lfc | wr_clk;

    // Settings in use
    wire       fast      = tic[TIC_FAST];
    wire       trig_en   = tic[TIC_TRIG_EN];
    wire       lvl_mode  = tic[TIC_LEVEL];
    wire       fifo      = lfc[LEN_FIFO];
    wire [3:0] len       = seq_len(lfc[LEN_LSB+3:LEN_LSB]);
    wire       scan      = ssc[SSC_SCAN];
    wire       multi_channel_sel      = ssc[SSC_MULTI_CHANNEL_SEL];

    // Trigger: active level after polarity, edge on rise of it
    wire       trig_act  = trig_lvl ~^ tic[TIC_POL];
    wire       trig_edge = trig_act & ~trig_prev;
    wire       trig_fire = trig_en & (lvl_mode ? trig_act : trig_edge);

    // Sequence events
    wire       seq_start = (wr_ssc & ~trig_en) | (state == ASC_ARM & trig_fire);
    wire       conv_end  = (state == ASC_BUSY) & core_done & ~wr_ssc & ~abort_wr;
    wire       last_conv = conv_end && (conv_cnt + 4'h1) == len;
    wire       restart   = last_conv & scan;
    wire       tovr_set  = (state == ASC_BUSY) & trig_en & ~lvl_mode & trig_edge;

    // Channel code for the next conversion
    wire [2:0] chan_step = multi_channel_sel ? chan + 3'h1 : chan;
    wire [2:0] chan_next = restart ? ssc[2:0] : chan_step;

    // Conversion clock enable
    wire       div_zero  = div_cnt == 5'h00;
    assign conv_tick = div_zero & div_phase;

    always_comb begin
        next_state = state;
        case (state)
            ASC_IDLE: begin
                next_state = state;
            end
            ASC_BUSY: begin
                if (last_conv && !scan) begin
                    next_state = trig_en ? ASC_ARM : ASC_IDLE;
                end
            end
            ASC_ARM: begin
                if (seq_start) begin
                    next_state = ASC_BUSY;
                end
            end
            default: begin
                next_state = ASC_IDLE;
            end
        endcase
        if (abort_wr) begin
            next_state = ASC_IDLE;
        end
        if (wr_ssc) begin
            next_state = trig_en ? ASC_ARM : ASC_BUSY;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ASC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Divider: reload from prescale, toggle phase; period 2(p+1)
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt   <= PRS_RESET;
            div_phase <= 1'b0;
        end else if (div_zero) begin
            div_cnt   <= clock_prescale_value;
            div_phase <= ~div_phase;
        end else begin
            div_cnt   <= div_cnt - 5'h01;
        end
    end

    // Trigger pin synchroniser; level changes once stages two and three agree
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            trig_s1   <= 1'b0;
            trig_s2   <= 1'b0;
            trig_s3   <= 1'b0;
            trig_lvl  <= 1'b0;
            // Previous level starts active, so no false edge after reset
            trig_prev <= ~TIC_RESET[TIC_POL];
        end else begin
            trig_s1   <= trig_pin;
            trig_s2   <= trig_s1;
            trig_s3   <= trig_s2;
            trig_prev <= trig_act;
            if (trig_s2 == trig_s3) begin
                trig_lvl <= trig_s3;
            end
        end
    end

    // Control registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tic <= TIC_RESET;
            lfc <= LEN_RESET;
            clock_prescale_value <= PRS_RESET;
            ssc <= SSC_RESET;
        end else begin
            if (wr_tic) begin
                tic <= pwdata[7:0];
            end
            if (wr_lfc) begin
                lfc <= pwdata[7:0];
            end
            if (wr_clk) begin
                clock_prescale_value <= pwdata[4:0];
            end
            if (wr_ssc) begin
                ssc <= pwdata[7:0];
            end
        end
    end

    // Sequence progress: channel, pointer, count, core handshake
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            chan       <= 3'h0;
            ptr        <= 3'h0;
            conv_cnt   <= 4'h0;
            core_start <= 1'b0;
            core_abort <= 1'b0;
        end else begin
            core_start <= 1'b0;
            core_abort <= wr_ssc | abort_wr;
            if (seq_start) begin
                chan       <= pwdata[2:0];
                conv_cnt   <= 4'h0;
                core_start <= 1'b1;
                if (state == ASC_ARM) begin
                    chan <= ssc[2:0];
                end
                if (!fifo) begin
                    ptr <= 3'h0;
                end
            end else if (wr_ssc || abort_wr) begin
                if (!fifo) begin
                    ptr <= 3'h0;
                end
            end else if (conv_end) begin
                ptr      <= ptr + 3'h1;
                // Channel holds after the last conversion of a single sequence
                if (!last_conv || scan) begin
                    chan <= chan_next;
                end
                conv_cnt <= last_conv ? 4'h0 : conv_cnt + 4'h1;
                core_start <= ~last_conv | scan;
                if (last_conv && !fifo) begin
                    ptr <= 3'h0;
                end
            end
        end
    end
    assign core_channel = chan;

    // Results and conversion flags, one per result register
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_res
            wire hit = conv_end && ptr == gi;
            wire clr = rd_res && res_idx == gi && (fast || ccf_armed[gi]);
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    result[gi]    <= '0;
                    ccf[gi]       <= 1'b0;
                    ccf_armed[gi] <= 1'b0;
                end else begin
                    if (hit) begin
                        result[gi] <= core_result;
                    end
                    if (hit) begin
                        ccf[gi] <= 1'b1;
                    end else if (clr || wr_ssc) begin
                        ccf[gi] <= 1'b0;
                    end
                    if (rd_ccf) begin
                        ccf_armed[gi] <= 1'b1;
                    end else if (rd_res && res_idx == gi) begin
                        ccf_armed[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Status flags; each set beats its clear
    wire done_clr = (wr_stat & pwdata[ST_DONE]) | wr_ssc | (fast & rd_res);
    wire tovr_clr = (wr_stat & pwdata[ST_TOVR]) | abort_wr | wr_ssc;
    wire rovr_clr = (wr_stat & pwdata[ST_ROVR]) | seq_start;
    wire rovr_set = conv_end & ccf[ptr];

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            done_flag <= 1'b0;
            tovr_flag <= 1'b0;
            rovr_flag <= 1'b0;
        end else begin
            if (last_conv) begin
                done_flag <= 1'b1;
            end else if (done_clr) begin
                done_flag <= 1'b0;
            end
            if (tovr_set) begin
                tovr_flag <= 1'b1;
            end else if (tovr_clr) begin
                tovr_flag <= 1'b0;
            end
            if (rovr_set) begin
                rovr_flag <= 1'b1;
            end else if (rovr_clr) begin
                rovr_flag <= 1'b0;
            end
        end
    end

    // Interrupt request and its readable flag
    wire irq_flag = tic[TIC_IRQ_EN] & done_flag;
    assign seq_irq = irq_flag;

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            OFS_TRIG:  rd_mux = {24'h0, tic[7:1], irq_flag};
            OFS_LEN:   rd_mux = {24'h0, lfc};
            OFS_CLK:   rd_mux = {27'h0, clock_prescale_value};
            OFS_START: rd_mux = {24'h0, ssc};
            OFS_STAT:  rd_mux = {24'h0, done_flag, 1'b0, tovr_flag, rovr_flag, 1'b0, ptr};
            OFS_TEST:  rd_mux = 32'h0000_0000;
            OFS_CCF:   rd_mux = {24'h0, ccf};
            default: begin
                if (is_res) begin
                    rd_mux = {{(32-RES_W){1'b0}}, result[res_idx]};
                end
            end
        endcase
    end

    // Read data and error are captured in the setup cycle so that
    // the access phase can complete with no wait state
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~mapped;
        end
    end
    assign pready = 1'b1;
endmodule : asc_sequencer

// ### include/asc_pkg.sv
// Purpose: Shared constants for the converter sequence controller
// Assumes: 32-bit APB, one register per aligned word, 8-bit control registers except 5-bit prescale, RES_W-bit results
// Notes:   Field positions are bit indexes within each register
package asc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_TRIG  = 8'h00;
    localparam logic [7:0] OFS_LEN   = 8'h04;
    localparam logic [7:0] OFS_CLK   = 8'h08;
    localparam logic [7:0] OFS_START = 8'h0c;
    localparam logic [7:0] OFS_STAT  = 8'h10;
    localparam logic [7:0] OFS_TEST  = 8'h14;
    localparam logic [7:0] OFS_CCF   = 8'h18;
    localparam logic [7:0] OFS_RES0  = 8'h20;
    localparam logic [7:0] OFS_RES7  = 8'h3c;
    // trigger_interrupt_control fields
    localparam int TIC_IRQ_FLAG = 0;
    localparam int TIC_IRQ_EN   = 1;
    localparam int TIC_TRIG_EN  = 2;
    localparam int TIC_LEVEL    = 3;
    localparam int TIC_POL      = 4;
    localparam int TIC_FAST     = 6;
    // length_fifo_control fields
    localparam int LEN_FIFO     = 2;
    localparam int LEN_LSB      = 3;
    // sequence_start_control fields
    localparam int SSC_MULTI_CHANNEL_SEL     = 4;
    localparam int SSC_SCAN     = 5;
    // sequence_status fields
    localparam int ST_ROVR      = 4;
    localparam int ST_TOVR      = 5;
    localparam int ST_DONE      = 7;
    // Reset values
    localparam logic [7:0] TIC_RESET = 8'h00;
    localparam logic [7:0] LEN_RESET = 8'h20;
    localparam logic [4:0] PRS_RESET = 5'h05;
    localparam logic [7:0] SSC_RESET = 8'h00;
    // Allowed conversion clock range, and the bus clock
    localparam int CONV_MIN_KHZ = 500;
    localparam int CONV_MAX_KHZ = 2000;
    localparam int CLOCK_KHZ    = 200000;

    typedef enum logic [1:0] {
        ASC_IDLE = 2'b00,
        ASC_BUSY = 2'b01,
        ASC_ARM  = 2'b10
    } asc_state_type;
endpackage : asc_pkg

// ### verif/asc_sequencer_props.sv
// Purpose: Port checks for the converter sequence controller
// Assumes: Sees only the top ports
// Notes:   Divider period judged from a shadow of prescale writes
`timescale 1ns/1ps
module asc_sequencer_props
    import asc_pkg::*;
#(
    parameter int CHANNELS = 8,
    parameter int RES_W    = 10
) (
    // Clock and reset
    input wire logic             clock,
    input wire logic             sys_rst,
    // APB
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [7:0]       paddr,
    input wire logic [31:0]      pwdata,
    input wire logic             pready,
    input wire logic [31:0]      prdata,
    input wire logic             pslverr,
    // Core and pins
    input wire logic             conv_tick,
    input wire logic             core_start,
    input wire logic             core_abort,
    input wire logic [2:0]       core_channel,
    input wire logic             core_done,
    input wire logic [RES_W-1:0] core_result,
    input wire logic             trig_pin,
    input wire logic             seq_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire        wr_acc = psel && penable && pwrite && pready;
    wire        rd_acc = psel && penable && !pwrite;
    wire        clk_wr = wr_acc && paddr == OFS_CLK;
    logic [4:0] clock_prescale_value;
    logic [6:0] gap;
    logic       seen;
    logic       dirty;
    // A prescale write may land mid-period, so that period is skipped
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            clock_prescale_value   <= PRS_RESET;
            gap   <= 7'd0;
            seen  <= 1'b0;
            dirty <= 1'b0;
        end else begin
            gap   <= conv_tick ? 7'd1 : gap + 7'd1;
            seen  <= seen | conv_tick;
            dirty <= clk_wr | (dirty & !conv_tick);
            clock_prescale_value   <= clk_wr ? pwdata[4:0] : clock_prescale_value;
        end
    end
    property p_tick_pulse; conv_tick |=> !conv_tick; endproperty
    property p_tick_period; conv_tick && seen && !dirty |-> gap == {1'b0, clock_prescale_value, 1'b0} + 7'd2;
    endproperty
    property p_abort; wr_acc && paddr <= OFS_START && paddr[1:0] == 2'b00 |=> core_abort;
    endproperty
    property p_abort_once; core_abort |=> !core_abort; endproperty
    property p_chan_hold; !core_start |-> $stable(core_channel); endproperty
    property p_irq_cause; $rose(seq_irq) && !$past(wr_acc) |-> $past(core_done); endproperty
    property p_start_clr; wr_acc && paddr == OFS_START |=> !seq_irq; endproperty
    property p_test_zero; rd_acc && paddr == OFS_TEST |-> prdata == 32'h0; endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick too wide");
    a_tick_period: assert property (p_tick_period) else $error("tick period");
    a_abort: assert property (p_abort) else $error("no abort");
    a_abort_once: assert property (p_abort_once) else $error("abort too wide");
    a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
    a_irq_cause: assert property (p_irq_cause) else $error("irq no cause");
    a_start_clr: assert property (p_start_clr) else $error("done kept");
    a_test_zero: assert property (p_test_zero) else $error("test reg");
    c_start: cover property (wr_acc && paddr == OFS_START);
    c_irq: cover property ($rose(seq_irq));
    c_chain: cover property (core_done ##1 core_start);
endmodule : asc_sequencer_props

// ### verif/asc_core_model.sv
// Purpose: Behavioural converter core
// Assumes: One answer per start; abort drops the conversion
// Notes:   Idle result lines toggle so stale data never looks valid
`timescale 1ns/1ps
module asc_core_model #(
    parameter int RES_W = 10
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // Requests
    input  wire logic             core_start,
    input  wire logic             core_abort,
    input  wire logic             conv_tick,
    input  wire logic [2:0]       core_channel,
    input  wire logic             slow,
    // Answer
    output logic                  core_done,
    output logic [RES_W-1:0]      core_result
);
    logic       busy;
    logic [2:0] left;
    logic [2:0] chan;
    logic [6:0] serial;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            busy        <= 1'b0;
            left        <= 3'd0;
            chan        <= 3'd0;
            serial      <= 7'd0;
            core_done   <= 1'b0;
            core_result <= '0;
        end else begin
            core_done   <= 1'b0;
            core_result <= ~core_result;
            if (core_start) begin
                busy <= 1'b1;
                left <= slow ? 3'd6 : 3'd0;
                chan <= core_channel;
            end else if (core_abort) begin
                busy <= 1'b0;
            end else if (busy && left == 3'd0) begin
                busy        <= 1'b0;
                core_done   <= 1'b1;
                core_result <= RES_W'({serial, chan});
                serial      <= serial + 7'd1;
            end else if (busy && conv_tick) begin
                left <= left - 3'd1;
            end
        end
    end
endmodule : asc_core_model

// ### verif/test_asc_sequencer.sv
// Purpose: Self-checking bench for the sequence controller
// Assumes: Zero-wait APB slave, core model on the far side
// Notes:   Writes to 00..0c swap in the pending channel list
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_asc_sequencer;
    import asc_pkg::*;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        trig_pin = 1'b0;
    logic        slow = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        pready, pslverr, conv_tick, core_start, core_abort, core_done, seq_irq;
    logic [31:0] prdata, e32;
    logic [2:0]  core_channel, e3, c;
    logic [9:0]  core_result;
    logic [2:0]  exp_ch[$], pend[$];
    logic [9:0]  res_log[$];
    logic        e1;
    logic [31:0] exp_rd[$];
    int          n_mismatch = 0, tests_run = 0, n_start = 0, n;
    asc_sequencer asc_sequencer_inst (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .conv_tick, .core_start, .core_abort,
        .core_channel, .core_done, .core_result, .trig_pin, .seq_irq);
    asc_core_model asc_core_model_inst (.clock, .sys_rst, .core_start, .core_abort,
        .conv_tick, .core_channel, .slow, .core_done, .core_result);
    initial begin
        forever #2.5 clock = ~clock;
    end
    always @(negedge clock) begin
        if (core_start === 1'b1) begin
            n_start++;
            e3 = (exp_ch.size() > 0) ? exp_ch.pop_front() : ~core_channel;
            `CHK("core_channel", e3, core_channel)
        end
        if (psel && penable && !pwrite) begin
            e32 = exp_rd.pop_front();
            `CHK("prdata", e32, prdata)
            e1 = !(paddr <= OFS_CCF || (paddr >= OFS_RES0 && paddr <= OFS_RES7));
            `CHK("pslverr", e1, pslverr)
        end
        if (core_done === 1'b1) begin
            res_log.push_back(core_result);
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge clock);
            k++;
        end
        if (k == 20) begin
            n_mismatch++;
            complete_run();
        end
        // Swap at the taking edge so old starts never meet new expectations
        if (wr && a <= OFS_START) begin
            exp_ch = pend;
            pend.delete();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic seq(input logic [2:0] ch, input int len, input logic multi_channel_sel, input int reps);
        for (int i = 0; i < len * reps; i++) pend.push_back(multi_channel_sel ? 3'(ch + i % len) : ch);
        n_start = 0;
        apb(1'b1, OFS_START, {26'h0, reps > 1, multi_channel_sel, 1'b0, ch});
    endtask : seq
    task automatic wt(input int cnt, input logic irq);
        int k;
        for (k = 0; k < 4000 && !(n_start >= cnt && (seq_irq === 1'b1 || !irq)); k++)
            @(posedge clock);
        if (k == 4000) begin
            n_mismatch++;
            complete_run();
        end
    endtask : wt
    initial begin
        void'($urandom(32'h3f6f));
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        rd(OFS_TRIG, {24'h0, TIC_RESET});
        rd(OFS_LEN, {24'h0, LEN_RESET});
        rd(OFS_CLK, {27'h0, PRS_RESET});
        rd(OFS_STAT, 32'h0);
        apb(1'b1, OFS_TEST, 32'hff);
        rd(OFS_TEST, 32'h0);
        rd(8'h1c, 32'h0);
        // A 200 MHz bus clock cannot reach the allowed conversion range;
        // the slowest divisors come nearest. The checker judges each period but the one the write lands in
        apb(1'b1, OFS_CLK, 32'($urandom % 4) + 32'h1c);
        repeat (100) @(posedge clock);
        apb(1'b1, OFS_TRIG, 32'h02);
        $display("test registers done");
        for (int l = 0; l < 10; l++) begin
            n = (l == 0 || l > 7) ? 8 : l;
            c = 3'($urandom);
            apb(1'b1, OFS_LEN, 32'(l << 3));
            seq(c, n, l[0], 1);
            wt(n, 1'b1);
            rd(OFS_STAT, 32'h80);
        end
        rd(OFS_TRIG, 32'h03);
        apb(1'b1, OFS_STAT, 32'h80);
        rd(OFS_STAT, 32'h0);
        $display("test lengths done");
        slow <= 1'b1;
        apb(1'b1, OFS_LEN, 32'h10);
        seq(3'd6, 2, 1'b1, 3);
        wt(4, 1'b1);
        apb(1'b1, OFS_LEN, 32'h10);
        repeat (60) @(posedge clock);
        rd(OFS_STAT, 32'h90);
        $display("test scan done");
        apb(1'b1, OFS_LEN, 32'h1c);
        seq(3'd0, 3, 1'b1, 1);
        wt(3, 1'b1);
        apb(1'b1, OFS_STAT, 32'h04);
        rd(OFS_STAT, 32'h83);
        apb(1'b1, OFS_LEN, 32'h2c);
        seq(3'd3, 5, 1'b1, 1);
        wt(5, 1'b1);
        rd(OFS_STAT, 32'h80);
        $display("test fifo done");
        apb(1'b1, OFS_LEN, 32'h10);
        apb(1'b1, OFS_TRIG, 32'h16);
        seq(3'd5, 2, 1'b0, 1);
        trig_pin <= 1'b1;
        wt(1, 1'b0);
        trig_pin <= 1'b0;
        repeat (3) @(posedge clock);
        trig_pin <= 1'b1;
        wt(2, 1'b1);
        rd(OFS_STAT, 32'ha0);
        apb(1'b1, OFS_TRIG, 32'h02);
        rd(OFS_STAT, 32'h80);
        $display("test trigger done");
        apb(1'b1, OFS_TRIG, 32'h42);
        res_log.delete();
        seq(3'd2, 2, 1'b1, 1);
        wt(2, 1'b1);
        rd(OFS_CCF, 32'h03);
        rd(OFS_RES0 + 8'h04, {22'h0, res_log[1]});
        rd(OFS_STAT, 32'h00);
        rd(OFS_CCF, 32'h01);
        $display("test fast clear done");
        complete_run();
    end
endmodule : test_asc_sequencer
bind asc_sequencer asc_sequencer_props #(.CHANNELS(CHANNELS), .RES_W(RES_W))
    asc_sequencer_props_inst (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .conv_tick, .core_start, .core_abort, .core_channel,
    .core_done, .core_result, .trig_pin, .seq_irq);
